// ==== design/ci_slot_module_control.sv ====
`timescale 1ns/1ps
// Contract
// (RULE_01) control registers at 00h and 09h
// (RULE_02) each slot governed by its own register
// (RULE_03) flip mask registers at 06h and 0Fh
// (RULE_04) mask acts only on returning stream bits
// (RULE_05) mask bit 1 inverts, 0 passes
// (RULE_06) input enable set needs present, no high route
// (RULE_07) input disabled holds stream toward module low
// (RULE_08) removal clears input enable and reset drive
// (RULE_09) through bit cleared without card or input
// (RULE_10) through set needs present, no route, input
// (RULE_11) through bit picks module path over bypass
// (RULE_12) reset bit shown on module reset pin
// (RULE_13) reset set needs a present card
// (RULE_14) card present bit read only
// (RULE_15) high route set needs card, stream bits low
module ci_slot_module_control #(
  parameter int DATA_W = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // configuration port
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_rd,
  output logic [7:0] cfg_rdata,
  // card detect pins, one per slot
  input wire logic slot_a_detect,
  input wire logic slot_b_detect,
  // module reset pins
  output logic slot_a_module_reset,
  output logic slot_b_module_reset,
  // address routing and access space toward each slot
  output logic slot_a_high_addr_route,
  output logic slot_b_high_addr_route,
  output logic [1:0] slot_a_space_select,
  output logic [1:0] slot_b_space_select,
  // stream from the front end, same clock
  input wire logic [DATA_W-1:0] ts_in_data,
  input wire logic ts_in_valid,
  input wire logic ts_in_sync,
  // slot a stream pins
  output logic [DATA_W-1:0] slot_a_to_mod_data,
  output logic slot_a_to_mod_valid,
  output logic slot_a_to_mod_sync,
  input wire logic [DATA_W-1:0] slot_a_ret_data,
  input wire logic slot_a_ret_valid,
  input wire logic slot_a_ret_sync,
  // slot b stream pins
  output logic [DATA_W-1:0] slot_b_to_mod_data,
  output logic slot_b_to_mod_valid,
  output logic slot_b_to_mod_sync,
  input wire logic [DATA_W-1:0] slot_b_ret_data,
  input wire logic slot_b_ret_valid,
  input wire logic slot_b_ret_sync,
  // stream toward the demultiplexer
  output logic [DATA_W-1:0] ts_out_data,
  output logic ts_out_valid,
  output logic ts_out_sync
);

  typedef struct packed {
    logic [1:0] det_s1; // first detect stage, read only by det_s2
    logic [1:0] det_s2; // detect level after the synchroniser
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    logic [7:0] mask_a;
    logic [7:0] mask_b;
    logic [7:0] rdata;
  } ctl_s;

  ctl_s st_q;
  ctl_s st_d;

  // write filter and forcing for one control register; the same checks apply
  // to both slots, each against its own state only
  function automatic logic [7:0] next_control(input logic [7:0] cur, input logic wr, input logic [7:0] wd,
                                              input logic present);
    logic [7:0] nx;
    nx = cur;
    if (wr) begin
      // clearing any bit but the presence bit is always accepted; only setting is checked
      nx[ci_slot_pkg::AUTO_ACTIVATE_BIT] = wd[ci_slot_pkg::AUTO_ACTIVATE_BIT];
      if (present) begin
        nx[ci_slot_pkg::SPACE_SELECT_HI:ci_slot_pkg::SPACE_SELECT_LO] =
          wd[ci_slot_pkg::SPACE_SELECT_HI:ci_slot_pkg::SPACE_SELECT_LO];
      end
      if (!wd[ci_slot_pkg::HIGH_ADDR_ROUTE_BIT] ||
          (present && !cur[ci_slot_pkg::STREAM_IN_ENABLE_BIT] && !cur[ci_slot_pkg::STREAM_THROUGH_BIT])) begin
        nx[ci_slot_pkg::HIGH_ADDR_ROUTE_BIT] = wd[ci_slot_pkg::HIGH_ADDR_ROUTE_BIT]; // RULE_15
      end
      if (!wd[ci_slot_pkg::STREAM_IN_ENABLE_BIT] ||
          (present && !cur[ci_slot_pkg::HIGH_ADDR_ROUTE_BIT])) begin
        nx[ci_slot_pkg::STREAM_IN_ENABLE_BIT] = wd[ci_slot_pkg::STREAM_IN_ENABLE_BIT]; // RULE_06
      end
      if (!wd[ci_slot_pkg::STREAM_THROUGH_BIT] ||
          (present && !cur[ci_slot_pkg::HIGH_ADDR_ROUTE_BIT] && cur[ci_slot_pkg::STREAM_IN_ENABLE_BIT])) begin
        nx[ci_slot_pkg::STREAM_THROUGH_BIT] = wd[ci_slot_pkg::STREAM_THROUGH_BIT]; // RULE_10
      end
      if (!wd[ci_slot_pkg::MODULE_RESET_BIT] || present) begin
        nx[ci_slot_pkg::MODULE_RESET_BIT] = wd[ci_slot_pkg::MODULE_RESET_BIT]; // RULE_13
      end
    end
    // presence bit follows the pin, never the write data
    nx[ci_slot_pkg::CARD_PRESENT_BIT] = present; // RULE_14
    // removal drops every control that needs a card
    if (!present) begin
      nx[ci_slot_pkg::MODULE_RESET_BIT] = 1'b0; // RULE_08
      nx[ci_slot_pkg::STREAM_IN_ENABLE_BIT] = 1'b0; // RULE_08
      nx[ci_slot_pkg::HIGH_ADDR_ROUTE_BIT] = 1'b0; // RULE_15
      nx[ci_slot_pkg::SPACE_SELECT_HI:ci_slot_pkg::SPACE_SELECT_LO] = 2'h0;
    end
    // the through path cannot outlive the input enable
    if (!present || !nx[ci_slot_pkg::STREAM_IN_ENABLE_BIT]) begin
      nx[ci_slot_pkg::STREAM_THROUGH_BIT] = 1'b0; // RULE_09
    end
    return nx;
  endfunction

  logic wr_ctl_a;
  logic wr_ctl_b;
  logic wr_mask_a;
  logic wr_mask_b;

  // address decode, one strobe per register
  always_comb begin
    wr_ctl_a = 1'b0;
    wr_ctl_b = 1'b0;
    wr_mask_a = 1'b0;
    wr_mask_b = 1'b0;
    if (cfg_addr == ci_slot_pkg::SLOT_A_CONTROL_OFF) begin // RULE_01
      wr_ctl_a = cfg_wr;
    end else if (cfg_addr == ci_slot_pkg::SLOT_B_CONTROL_OFF) begin // RULE_01
      wr_ctl_b = cfg_wr;
    end else if (cfg_addr == ci_slot_pkg::SLOT_A_FLIP_MASK_OFF) begin // RULE_03
      wr_mask_a = cfg_wr;
    end else if (cfg_addr == ci_slot_pkg::SLOT_B_FLIP_MASK_OFF) begin // RULE_03
      wr_mask_b = cfg_wr;
    end
  end

  // next-state logic for all register state
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      // detect pins come from the slot connector, hence two stages
      st_d.det_s1 = {slot_b_detect, slot_a_detect};
      st_d.det_s2 = st_q.det_s1;
      // each slot sees only its own write strobe and detect level
      st_d.ctl_a = next_control(st_q.ctl_a, wr_ctl_a, cfg_wdata, st_q.det_s2[0]); // RULE_02
      st_d.ctl_b = next_control(st_q.ctl_b, wr_ctl_b, cfg_wdata, st_q.det_s2[1]); // RULE_02
      if (wr_mask_a) begin
        st_d.mask_a = cfg_wdata; // RULE_03
      end
      if (wr_mask_b) begin
        st_d.mask_b = cfg_wdata; // RULE_03
      end
      // read data registered one cycle after the strobe; unmapped reads zero
      if (cfg_rd) begin
        if (cfg_addr == ci_slot_pkg::SLOT_A_CONTROL_OFF) begin
          st_d.rdata = st_q.ctl_a;
        end else if (cfg_addr == ci_slot_pkg::SLOT_B_CONTROL_OFF) begin
          st_d.rdata = st_q.ctl_b;
        end else if (cfg_addr == ci_slot_pkg::SLOT_A_FLIP_MASK_OFF) begin
          st_d.rdata = st_q.mask_a;
        end else if (cfg_addr == ci_slot_pkg::SLOT_B_FLIP_MASK_OFF) begin
          st_d.rdata = st_q.mask_b;
        end else begin
          st_d.rdata = ci_slot_pkg::READ_IDLE;
        end
      end
    end
  end

  // state register; reset leaves every slot idle and bypassed
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q.det_s1 <= 2'h0;
      st_q.det_s2 <= 2'h0;
      st_q.ctl_a <= ci_slot_pkg::CONTROL_RESET;
      st_q.ctl_b <= ci_slot_pkg::CONTROL_RESET;
      st_q.mask_a <= ci_slot_pkg::FLIP_MASK_RESET;
      st_q.mask_b <= ci_slot_pkg::FLIP_MASK_RESET;
      st_q.rdata <= ci_slot_pkg::READ_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // register-backed outputs
  assign cfg_rdata = st_q.rdata;
  assign slot_a_module_reset = st_q.ctl_a[ci_slot_pkg::MODULE_RESET_BIT]; // RULE_12
  assign slot_b_module_reset = st_q.ctl_b[ci_slot_pkg::MODULE_RESET_BIT]; // RULE_12
  assign slot_a_high_addr_route = st_q.ctl_a[ci_slot_pkg::HIGH_ADDR_ROUTE_BIT];
  assign slot_b_high_addr_route = st_q.ctl_b[ci_slot_pkg::HIGH_ADDR_ROUTE_BIT];
  assign slot_a_space_select = st_q.ctl_a[ci_slot_pkg::SPACE_SELECT_HI:ci_slot_pkg::SPACE_SELECT_LO];
  assign slot_b_space_select = st_q.ctl_b[ci_slot_pkg::SPACE_SELECT_HI:ci_slot_pkg::SPACE_SELECT_LO];

  // stream between slot a and slot b
  logic [DATA_W-1:0] mid_data;
  logic mid_valid;
  logic mid_sync;

  // slot a sits first in the daisy chain
  slot_stream_path #(.DATA_W(DATA_W)) u_path_a (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .stream_enable(st_q.ctl_a[ci_slot_pkg::STREAM_IN_ENABLE_BIT]),
    .through_module(st_q.ctl_a[ci_slot_pkg::STREAM_THROUGH_BIT]),
    .flip_mask(st_q.mask_a[DATA_W-1:0]),
    .up_data(ts_in_data),
    .up_valid(ts_in_valid),
    .up_sync(ts_in_sync),
    .to_mod_data(slot_a_to_mod_data),
    .to_mod_valid(slot_a_to_mod_valid),
    .to_mod_sync(slot_a_to_mod_sync),
    .ret_data(slot_a_ret_data),
    .ret_valid(slot_a_ret_valid),
    .ret_sync(slot_a_ret_sync),
    .down_data(mid_data),
    .down_valid(mid_valid),
    .down_sync(mid_sync)
  );

  // slot b takes whatever slot a passed on
  slot_stream_path #(.DATA_W(DATA_W)) u_path_b (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .stream_enable(st_q.ctl_b[ci_slot_pkg::STREAM_IN_ENABLE_BIT]),
    .through_module(st_q.ctl_b[ci_slot_pkg::STREAM_THROUGH_BIT]),
    .flip_mask(st_q.mask_b[DATA_W-1:0]),
    .up_data(mid_data),
    .up_valid(mid_valid),
    .up_sync(mid_sync),
    .to_mod_data(slot_b_to_mod_data),
    .to_mod_valid(slot_b_to_mod_valid),
    .to_mod_sync(slot_b_to_mod_sync),
    .ret_data(slot_b_ret_data),
    .ret_valid(slot_b_ret_valid),
    .ret_sync(slot_b_ret_sync),
    .down_data(ts_out_data),
    .down_valid(ts_out_valid),
    .down_sync(ts_out_sync)
  );

  // helper views for the checks below
  logic a_present;
  logic a_in_en;
  logic a_through;
  logic a_route;
  assign a_present = st_q.det_s2[0];
  assign a_in_en = st_q.ctl_a[ci_slot_pkg::STREAM_IN_ENABLE_BIT];
  assign a_through = st_q.ctl_a[ci_slot_pkg::STREAM_THROUGH_BIT];
  assign a_route = st_q.ctl_a[ci_slot_pkg::HIGH_ADDR_ROUTE_BIT];

  sequence write_a_s;
    clk_en && wr_ctl_a;
  endsequence

  sequence absent_a_s;
    clk_en && !a_present;
  endsequence

  ctl_addr_map_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE_01
    clk_en && cfg_rd && cfg_addr == ci_slot_pkg::SLOT_B_CONTROL_OFF |=> cfg_rdata == $past(st_q.ctl_b))
    else $error("slot b control not read at its offset");

  mask_write_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE_03
    clk_en && wr_mask_a |=> st_q.mask_a == $past(cfg_wdata))
    else $error("slot a mask write lost");

  // with b's presence already settled, a write to a must leave b untouched
  slot_indep_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE_02
    write_a_s ##0 (st_q.det_s2[1] == st_q.ctl_b[ci_slot_pkg::CARD_PRESENT_BIT]) |=> $stable(st_q.ctl_b))
    else $error("slot a write disturbed slot b");

  in_enable_guard_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE_06
    write_a_s ##0 (!a_in_en && (!a_present || a_route)) |=> !a_in_en)
    else $error("input enable set while not allowed");

  removal_clear_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE_08
    absent_a_s |=> !a_in_en && !slot_a_module_reset && !a_route)
    else $error("controls survive module removal");

  // stored state must never show through without card or input enable
  through_force_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE_09
    (!st_q.ctl_a[ci_slot_pkg::CARD_PRESENT_BIT] || !a_in_en) |-> !a_through)
    else $error("through bit kept without input enable");

  through_guard_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE_10
    write_a_s ##0 (!a_through && (!a_in_en || a_route)) |=> !a_through)
    else $error("through bit set while not allowed");

  reset_guard_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE_13
    write_a_s ##0 !a_present |=> !slot_a_module_reset)
    else $error("reset drive set without module");

  present_follow_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE_14
    clk_en |=> st_q.ctl_a[ci_slot_pkg::CARD_PRESENT_BIT] == $past(a_present))
    else $error("presence bit not following detect");

  route_guard_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE_15
    write_a_s ##0 (!a_route && (a_in_en || a_through)) |=> !a_route)
    else $error("high route set while stream active");

endmodule // ci_slot_module_control

// ==== design/ci_slot_pkg.sv ====
package ci_slot_pkg;

  // register offsets on the configuration port
  localparam logic [7:0] SLOT_A_CONTROL_OFF = 8'h00;
  localparam logic [7:0] SLOT_A_FLIP_MASK_OFF = 8'h06;
  localparam logic [7:0] SLOT_B_CONTROL_OFF = 8'h09;
  localparam logic [7:0] SLOT_B_FLIP_MASK_OFF = 8'h0f;

  // control register field positions
  localparam int CARD_PRESENT_BIT = 0;
  localparam int AUTO_ACTIVATE_BIT = 1;
  localparam int SPACE_SELECT_LO = 2;
  localparam int SPACE_SELECT_HI = 3;
  localparam int HIGH_ADDR_ROUTE_BIT = 4;
  localparam int STREAM_IN_ENABLE_BIT = 5;
  localparam int STREAM_THROUGH_BIT = 6;
  localparam int MODULE_RESET_BIT = 7;

  // values after reset
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] FLIP_MASK_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // cycle counts
  localparam int SYNC_STAGES = 2;
  localparam int STREAM_LATENCY = 1;

endpackage

// ==== design/slot_stream_path.sv ====
`timescale 1ns/1ps
// one slot's stream stage: gates the stream toward the module, flips the
// returning bits and chooses between the module's return and the bypass
module slot_stream_path #(
  parameter int DATA_W = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic stream_enable,
  input wire logic through_module,
  input wire logic [DATA_W-1:0] flip_mask,
  input wire logic [DATA_W-1:0] up_data,
  input wire logic up_valid,
  input wire logic up_sync,
  output logic [DATA_W-1:0] to_mod_data,
  output logic to_mod_valid,
  output logic to_mod_sync,
  input wire logic [DATA_W-1:0] ret_data,
  input wire logic ret_valid,
  input wire logic ret_sync,
  output logic [DATA_W-1:0] down_data,
  output logic down_valid,
  output logic down_sync
);

  typedef struct packed {
    logic [DATA_W+1:0] ret_s1; // first synchroniser stage, read only by ret_s2
    logic [DATA_W+1:0] ret_s2; // module return, now in our domain
    logic [DATA_W-1:0] to_data;
    logic to_valid;
    logic to_sync;
    logic [DATA_W-1:0] dn_data;
    logic dn_valid;
    logic dn_sync;
  } path_s;

  path_s st_q;
  path_s st_d;

  // next-state logic
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      st_d.ret_s1 = {ret_sync, ret_valid, ret_data};
      st_d.ret_s2 = st_q.ret_s1;
      // a disabled input holds every line toward the module low
      if (stream_enable) begin // RULE_07
        st_d.to_data = up_data;
        st_d.to_valid = up_valid;
        st_d.to_sync = up_sync;
      end else begin
        st_d.to_data = '0;
        st_d.to_valid = 1'b0;
        st_d.to_sync = 1'b0;
      end
      // through the module the mask flips returning bits; bypass is untouched
      if (through_module) begin // RULE_11
        st_d.dn_data = st_q.ret_s2[DATA_W-1:0] ^ flip_mask; // RULE_04 RULE_05
        st_d.dn_valid = st_q.ret_s2[DATA_W];
        st_d.dn_sync = st_q.ret_s2[DATA_W+1];
      end else begin
        st_d.dn_data = up_data;
        st_d.dn_valid = up_valid;
        st_d.dn_sync = up_sync;
      end
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign to_mod_data = st_q.to_data;
  assign to_mod_valid = st_q.to_valid;
  assign to_mod_sync = st_q.to_sync;
  assign down_data = st_q.dn_data;
  assign down_valid = st_q.dn_valid;
  assign down_sync = st_q.dn_sync;

  sequence flip_in_s;
    clk_en && through_module ##0 $stable(flip_mask);
  endsequence

  flip_data_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE_05
    flip_in_s |=> down_data == ($past(st_q.ret_s2[DATA_W-1:0]) ^ $past(flip_mask)))
    else $error("returning data not flipped by mask");

  bypass_data_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE_04
    clk_en && !through_module |=> down_data == $past(up_data))
    else $error("bypass data altered");

  gate_low_a: assert property (@(posedge clock) disable iff (!rst_b) // RULE_07
    clk_en && !stream_enable |=> to_mod_data == '0 && !to_mod_valid && !to_mod_sync)
    else $error("stream toward module not held low");

endmodule // slot_stream_path

// ==== bench/ci_module_model.sv ====
`timescale 1ns/1ps
// behavioural card in a slot: echoes the stream it receives back on the
// return pins one cycle late; while pulled or held in reset it lets go of them
module ci_module_model #(
  parameter int DATA_W = 8
) (
  input wire logic clock,
  input wire logic inserted, // the bench inserts or pulls the card
  input wire logic module_reset,
  input wire logic [DATA_W-1:0] to_mod_data,
  input wire logic to_mod_valid,
  input wire logic to_mod_sync,
  output logic detect,
  output logic [DATA_W-1:0] ret_data,
  output logic ret_valid,
  output logic ret_sync
);
  // detect pin follows the card at once; the device does the synchronising
  assign detect = inserted;

  // last sample echoed; known start so the first toggle is defined
  logic [DATA_W+1:0] echo_q = '0;

  assign ret_data = echo_q[DATA_W-1:0];
  assign ret_valid = echo_q[DATA_W];
  assign ret_sync = echo_q[DATA_W+1];

  // released lines toggle every cycle so a stale echo can never pass for data
  always @(posedge clock) begin
    if (inserted && !module_reset) begin
      echo_q <= #1 {to_mod_sync, to_mod_valid, to_mod_data};
    end else begin
      echo_q <= #1 ~echo_q;
    end
  end
endmodule // ci_module_model

// ==== bench/ci_slot_module_control_test.sv ====
`timescale 1ns/1ps
// self-checking bench: registers through the configuration port, a card
// model in each slot, stream checked at the demultiplexer side
module ci_slot_module_control_test;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic cfg_wr = 1'b0;
  logic [7:0] cfg_wdata = 8'h00;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_rdata;
  logic [7:0] ts_in_data = 8'h00;
  logic ts_in_valid = 1'b1;
  logic ts_in_sync = 1'b0;
  logic in_a = 1'b0; // card a inserted
  logic in_b = 1'b0; // card b stays out
  logic det_a, det_b, rst_a, rst_b_pin, route_a, route_b;
  logic [1:0] space_a, space_b;
  logic [7:0] tm_a, tm_b, rt_a, rt_b, ts_out_data;
  logic tmv_a, tms_a, tmv_b, tms_b, rv_a, rs_a, rv_b, rs_b, ts_out_valid, ts_out_sync;
  int failures = 0;
  int n_checks = 0;

  // 50 MHz
  always #10 clock = ~clock;

  ci_slot_module_control #(.DATA_W(8)) i_dut (.clock(clock), .rst_b(rst_b), .clk_en(1'b1),
    .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .slot_a_detect(det_a), .slot_b_detect(det_b), .slot_a_module_reset(rst_a), .slot_b_module_reset(rst_b_pin),
    .slot_a_high_addr_route(route_a), .slot_b_high_addr_route(route_b), .slot_a_space_select(space_a),
    .slot_b_space_select(space_b), .ts_in_data(ts_in_data), .ts_in_valid(ts_in_valid), .ts_in_sync(ts_in_sync),
    .slot_a_to_mod_data(tm_a), .slot_a_to_mod_valid(tmv_a), .slot_a_to_mod_sync(tms_a),
    .slot_a_ret_data(rt_a), .slot_a_ret_valid(rv_a), .slot_a_ret_sync(rs_a),
    .slot_b_to_mod_data(tm_b), .slot_b_to_mod_valid(tmv_b), .slot_b_to_mod_sync(tms_b),
    .slot_b_ret_data(rt_b), .slot_b_ret_valid(rv_b), .slot_b_ret_sync(rs_b),
    .ts_out_data(ts_out_data), .ts_out_valid(ts_out_valid), .ts_out_sync(ts_out_sync));

  ci_module_model #(.DATA_W(8)) i_card_a (.clock(clock), .inserted(in_a), .module_reset(rst_a),
    .to_mod_data(tm_a), .to_mod_valid(tmv_a), .to_mod_sync(tms_a), .detect(det_a),
    .ret_data(rt_a), .ret_valid(rv_a), .ret_sync(rs_a));
  ci_module_model #(.DATA_W(8)) i_card_b (.clock(clock), .inserted(in_b), .module_reset(rst_b_pin),
    .to_mod_data(tm_b), .to_mod_valid(tmv_b), .to_mod_sync(tms_b), .detect(det_b),
    .ret_data(rt_b), .ret_valid(rv_b), .ret_sync(rs_b));

  // one comparison, counted; four-state compare so unknowns fail
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe, released after the taking edge
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(posedge clock);
    #1;
    cfg_wr = 1'b0;
  endtask

  // read strobe, data settled just after the edge that took it
  task automatic cfg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(posedge clock);
    #1;
    cfg_rd = 1'b0;
    d = cfg_rdata;
  endtask

  // write then read back the stored value
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    cfg_write(a, d);
    cfg_read(a, q);
  endtask

  // new stream sample just after an edge
  task automatic send(input logic [7:0] d);
    @(posedge clock);
    #1;
    ts_in_data = d;
  endtask

  task automatic t_reset_values;
    logic [7:0] q;
    cfg_read(ci_slot_pkg::SLOT_A_CONTROL_OFF, q);
    check(q, ci_slot_pkg::CONTROL_RESET);
    cfg_read(ci_slot_pkg::SLOT_B_CONTROL_OFF, q);
    check(q, ci_slot_pkg::CONTROL_RESET);
    cfg_read(ci_slot_pkg::SLOT_A_FLIP_MASK_OFF, q);
    check(q, ci_slot_pkg::FLIP_MASK_RESET);
    cfg_read(ci_slot_pkg::SLOT_B_FLIP_MASK_OFF, q);
    check(q, ci_slot_pkg::FLIP_MASK_RESET);
  endtask

  // no card: every guarded set dropped, present bit not writable, masks plain
  task automatic t_absent_guards;
    logic [7:0] q;
    wr_rd(ci_slot_pkg::SLOT_A_CONTROL_OFF, 8'hfd, q);
    check(q, 8'h00);
    wr_rd(ci_slot_pkg::SLOT_A_CONTROL_OFF, 8'h01, q);
    check(q, 8'h00);
    wr_rd(ci_slot_pkg::SLOT_A_FLIP_MASK_OFF, 8'ha5, q);
    check(q, 8'ha5);
    wr_rd(ci_slot_pkg::SLOT_B_FLIP_MASK_OFF, 8'hff, q);
    check(q, 8'hff);
    wr_rd(8'h03, 8'h77, q);
    check(q, 8'h00);
  endtask

  // card a in: order of sets decides what sticks
  task automatic t_setup_bits;
    logic [7:0] q;
    in_a = 1'b1;
    repeat (5) @(posedge clock);
    cfg_read(ci_slot_pkg::SLOT_A_CONTROL_OFF, q);
    check(q, 8'h01);
    wr_rd(ci_slot_pkg::SLOT_A_CONTROL_OFF, 8'h40, q);
    check(q, 8'h01);
    wr_rd(ci_slot_pkg::SLOT_A_CONTROL_OFF, 8'h10, q);
    check(q, 8'h11);
    check({7'h00, route_a}, 8'h01);
    wr_rd(ci_slot_pkg::SLOT_A_CONTROL_OFF, 8'h30, q);
    check(q, 8'h11);
    wr_rd(ci_slot_pkg::SLOT_A_CONTROL_OFF, 8'h12, q);
    check(q, 8'h13);
    wr_rd(ci_slot_pkg::SLOT_A_CONTROL_OFF, 8'h00, q);
    check(q, 8'h01);
    cfg_read(ci_slot_pkg::SLOT_B_CONTROL_OFF, q);
    check(q, 8'h00);
  endtask

  // gating toward the module and bypass timing; masks idle on bypass
  task automatic t_stream_gate;
    logic [7:0] q;
    send(8'h5a);
    @(posedge clock);
    #1;
    check(tm_a, 8'h00);
    check({6'h00, tmv_a, tms_a}, 8'h00);
    @(posedge clock);
    #1;
    check(ts_out_data, 8'h5a);
    check({6'h00, ts_out_valid, ts_out_sync}, 8'h02);
    wr_rd(ci_slot_pkg::SLOT_A_CONTROL_OFF, 8'h20, q);
    check(q, 8'h21);
    wr_rd(ci_slot_pkg::SLOT_A_CONTROL_OFF, 8'h30, q);
    check(q, 8'h21);
    send(8'hc3);
    ts_in_sync = 1'b1;
    @(posedge clock);
    #1;
    check(tm_a, 8'hc3);
    check({6'h00, tmv_a, tms_a}, 8'h03);
    @(posedge clock);
    #1;
    check(ts_out_data, 8'hc3);
    check({6'h00, ts_out_valid, ts_out_sync}, 8'h03);
    ts_in_sync = 1'b0;
  endtask

  // through module a: returned bits flipped by a's mask only
  task automatic t_through;
    logic [7:0] q;
    wr_rd(ci_slot_pkg::SLOT_A_CONTROL_OFF, 8'h60, q);
    check(q, 8'h61);
    wr_rd(ci_slot_pkg::SLOT_A_FLIP_MASK_OFF, 8'h0f, q);
    check(q, 8'h0f);
    send(8'h3c);
    repeat (10) @(posedge clock);
    #1;
    check(ts_out_data, 8'h33);
    check({6'h00, ts_out_valid, ts_out_sync}, 8'h02);
    check(tm_b, 8'h00);
    check({3'h0, route_b, space_b, tmv_b, tms_b}, 8'h00);
    wr_rd(ci_slot_pkg::SLOT_A_CONTROL_OFF, 8'hec, q);
    check(q, 8'hed);
    check({6'h00, space_a}, 8'h03);
    check({7'h00, rst_a}, 8'h01);
    check({7'h00, rst_b_pin}, 8'h00);
  endtask

  // dropping the enable clears through; pulling the card clears the rest
  task automatic t_removal;
    logic [7:0] q;
    wr_rd(ci_slot_pkg::SLOT_A_CONTROL_OFF, 8'hcc, q);
    check(q, 8'h8d);
    wr_rd(ci_slot_pkg::SLOT_A_CONTROL_OFF, 8'h9c, q);
    check(q, 8'h9d);
    in_a = 1'b0;
    repeat (5) @(posedge clock);
    cfg_read(ci_slot_pkg::SLOT_A_CONTROL_OFF, q);
    check(q, 8'h00);
    check({5'h00, rst_a, space_a}, 8'h00);
    check({7'h00, route_a}, 8'h00);
  endtask

  // single exit of the run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clock);
    #1;
    rst_b = 1'b1;
    t_reset_values();
    t_absent_guards();
    t_setup_bits();
    t_stream_gate();
    t_through();
    t_removal();
    print_verdict();
  end

  // watchdog, far beyond the roughly 130 cycles the tests need
  initial begin
    #(20 * 5000);
    failures++;
    print_verdict();
  end
endmodule // ci_slot_module_control_test
